// ===== logic/background_debug_control.sv
`timescale 1ns/1ps
module background_debug_control (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SPECIAL_MODE_LOW,
  input wire logic SPECIAL_SINGLE_CHIP,
  input wire logic SPECIAL_PERIPHERAL,
  input wire logic SHADOW_LOCKOUT_DISABLE,
  input wire logic CFG_WR,
  input wire logic CFG_WR_DATA,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic HIT,
  input wire logic SER_FALL,
  input wire logic SER_CMD_VALID,
  input wire logic [7:0] SER_CMD,
  input wire logic SHIFT_DONE,
  input wire logic SHIFT_START,
  input wire logic [15:0] SHIFT_LOAD,
  input wire logic [15:0] ADDR_LOAD,
  input wire logic ADDR_LOAD_EN,
  input wire logic ENTER_DEBUG,
  input wire logic SINGLE_STEP,
  input wire logic TAG_RESUME,
  input wire logic BUS_SLOWER,
  input wire logic [7:0] FLAGS_IN,
  input wire logic BUS_ACK,
  output logic LOCKOUT_DISABLE,
  output logic DEBUG_ACTIVE,
  output logic ROM_MAPPED,
  output logic RESET_VECTOR_BLOCK,
  output logic USE_BUS_CLOCK,
  output logic TAGGING,
  output logic SERIAL_ENABLE,
  output logic BACKGROUND_REQUEST_BIT_REQ,
  output logic HW_CMD,
  output logic HW_DATA,
  output logic HW_READ,
  output logic HW_WORD,
  output logic HW_MAP_SELECT,
  output logic FREEZE,
  output logic BUS_HOLD
);
  import debug_ctrl_pkg::*;

  logic lockout_disable_q;
  logic [7:0] instr_q;
  logic [7:0] status_q;
  logic [15:0] shift_q;
  logic [15:0] taddr_q;
  logic [7:0] flags_q;
  logic [2:0] act_cnt_q;
  logic act_val_q;
  logic [4:0] tag_cnt_q;
  logic tag_q;
  logic [9:0] idle_q;
  logic rst_seen_q;
  logic [7:0] status_d;
  logic permit;
  logic map_on;
  logic wr_instr;
  logic wr_status;
  logic access_req;

  debug_access_if acc ();

  function automatic logic reg_sel(input logic [15:0] a,
                                   input logic [15:0] t);
    reg_sel = (a == t);
  endfunction : reg_sel

  ////////////////////////////////////////////////////////////////////
  // Lockout: strap reloaded after every reset release
  // reload from shadow
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      rst_seen_q <= 1'b0;
    else
      rst_seen_q <= 1'b1;
  end
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      lockout_disable_q <= 1'b0;
    else if (!rst_seen_q)
      lockout_disable_q <= SHADOW_LOCKOUT_DISABLE;
    else if (CFG_WR && !SPECIAL_MODE_LOW)
      lockout_disable_q <= CFG_WR_DATA;
  end
  assign LOCKOUT_DISABLE = lockout_disable_q;
  assign RESET_VECTOR_BLOCK = !lockout_disable_q && SPECIAL_SINGLE_CHIP;

  ////////////////////////////////////////////////////////////////////
  // lockout kills active state
  assign permit = status_q[BIT_PERMIT] && lockout_disable_q;
  assign DEBUG_ACTIVE = status_q[BIT_ACTIVE] && lockout_disable_q;
  assign ROM_MAPPED = DEBUG_ACTIVE;
  // map-select opens it briefly
  // Map select counts only for hardware commands
  assign map_on = lockout_disable_q &&
                  (status_q[BIT_ACTIVE] ||
                   (instr_q[BIT_HWFW] && instr_q[BIT_MAP]));
  assign HIT = map_on && (ADDR >= ADDR_INSTR) && (ADDR <= ADDR_FLAGS);
  assign wr_instr = HIT && WR && reg_sel(ADDR, ADDR_INSTR);
  assign wr_status = HIT && WR && reg_sel(ADDR, ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////
  // Instruction register
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      idle_q <= 10'h000;
    else if (SER_FALL)
      idle_q <= 10'h000;
    else if (idle_q != IDLE_CLEAR_W)
      idle_q <= idle_q + 10'h001;
  end
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      instr_q <= 8'h00;
    else if (idle_q == IDLE_CLEAR_W && !SER_FALL)
      instr_q <= 8'h00;
    else if (SER_CMD_VALID && !tag_q)
      instr_q <= SER_CMD & INSTR_MASK;
    else if (wr_instr)
      instr_q <= WDATA & INSTR_MASK;
  end
  assign HW_CMD = instr_q[BIT_HWFW];
  assign HW_DATA = instr_q[BIT_DATA];
  assign HW_READ = instr_q[BIT_READ];
  assign HW_WORD = instr_q[BIT_WORD];
  assign HW_MAP_SELECT = instr_q[BIT_MAP];
  assign BACKGROUND_REQUEST_BIT_REQ = (instr_q == INSTR_BACKGROUND_REQUEST_BIT_CMD) && permit;

  ////////////////////////////////////////////////////////////////////
  // Status register
  always_comb
  begin
    status_d = status_q;
    if (wr_status)
    begin
      status_d = (status_q & ~STATUS_ALWAYS_WR) |
                 (WDATA & STATUS_ALWAYS_WR);
      if (instr_q[BIT_HWFW])
        status_d[BIT_CLKSEL] = WDATA[BIT_CLKSEL];
      status_d[BIT_ACTIVE] = status_q[BIT_ACTIVE];
    end
    if (SHIFT_START)
      status_d[BIT_SVALID] = 1'b0;
    if (SHIFT_DONE)
      status_d[BIT_SVALID] = 1'b1;
    if (SINGLE_STEP)
      status_d[BIT_TRACE] = 1'b1;
    if (act_val_q)
      status_d[BIT_ACTIVE] = 1'b0;
    if (ENTER_DEBUG && permit)
    begin
      status_d[BIT_ACTIVE] = 1'b1;
      status_d[BIT_TAG] = 1'b0;
    end
    if (TAG_RESUME)
      status_d[BIT_TAG] = 1'b1;
    if (!lockout_disable_q)
      status_d[BIT_ACTIVE] = 1'b0;
    status_d[1:0] = 2'b00;
  end
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      status_q <= STATUS_RST_OTHER;
    else if (!rst_seen_q)
      status_q <= (SPECIAL_SINGLE_CHIP || SPECIAL_PERIPHERAL) ?
                  STATUS_RST_SPECIAL : STATUS_RST_OTHER;
    else
      status_q <= status_d;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      act_cnt_q <= 3'h0;
      act_val_q <= 1'b0;
    end
    else if (wr_status && !instr_q[BIT_HWFW] && !WDATA[BIT_ACTIVE])
    begin
      act_cnt_q <= ACTIVE_DLY_W - 3'h1;
      act_val_q <= 1'b0;
    end
    else if (act_cnt_q != 3'h0)
    begin
      act_cnt_q <= act_cnt_q - 3'h1;
      act_val_q <= (act_cnt_q == 3'h1);
    end
    else
      act_val_q <= 1'b0;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      tag_cnt_q <= 5'h00;
    else if (!status_q[BIT_TAG])
      tag_cnt_q <= 5'h00;
    else if (tag_cnt_q != TAG_DLY_W)
      tag_cnt_q <= tag_cnt_q + 5'h01;
  end
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      tag_q <= 1'b0;
    else
      tag_q <= status_q[BIT_TAG] && (tag_cnt_q >= TAG_DLY_W - 5'h01);
  end
  assign TAGGING = tag_q;
  assign SERIAL_ENABLE = !tag_q;

  assign USE_BUS_CLOCK = status_q[BIT_CLKSEL] || BUS_SLOWER;

  ////////////////////////////////////////////////////////////////////
  // Data registers
  always_ff @(posedge MCLK)
  begin
    if (SHIFT_DONE)
      shift_q <= SHIFT_LOAD;
    else if (HIT && WR && reg_sel(ADDR, ADDR_SHIFT_HI))
      shift_q[15:8] <= WDATA;
    else if (HIT && WR && reg_sel(ADDR, ADDR_SHIFT_LO))
      shift_q[7:0] <= WDATA;
  end
  always_ff @(posedge MCLK)
  begin
    if (ADDR_LOAD_EN)
      taddr_q <= ADDR_LOAD;
  end
  always_ff @(posedge MCLK)
  begin
    if (ENTER_DEBUG && permit)
      flags_q <= FLAGS_IN;
    else if (HIT && WR && reg_sel(ADDR, ADDR_FLAGS))
      flags_q <= WDATA;
  end
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (HIT && RD)
    begin
      if (reg_sel(ADDR, ADDR_INSTR))
        RDATA <= instr_q;
      else if (reg_sel(ADDR, ADDR_STATUS))
        RDATA <= status_q;
      else if (reg_sel(ADDR, ADDR_SHIFT_HI))
        RDATA <= shift_q[15:8];
      else if (reg_sel(ADDR, ADDR_SHIFT_LO))
        RDATA <= shift_q[7:0];
      else if (reg_sel(ADDR, ADDR_TADDR_HI))
        RDATA <= taddr_q[15:8];
      else if (reg_sel(ADDR, ADDR_TADDR_LO))
        RDATA <= taddr_q[7:0];
      else
        RDATA <= flags_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // hardware access steals bus
  assign access_req = SER_CMD_VALID && !tag_q &&
                      SER_CMD[BIT_HWFW] && !SER_CMD[BIT_BACKGROUND_REQUEST_BIT];
  assign acc.req = access_req;
  assign acc.multi = SER_CMD[BIT_WORD];
  debug_access_seq u_seq (
    .MCLK(MCLK),
    .RST(RST),
    .acc(acc),
    .bus_ack(BUS_ACK),
    .freeze_q(FREEZE),
    .hold_q(BUS_HOLD)
  );

  ////////////////////////////////////////////////////////////////////
  AST_LOCKOUT_INACTIVE: assert property (@(posedge MCLK) disable iff (RST)
    !lockout_disable_q |-> !DEBUG_ACTIVE && !ROM_MAPPED)
    else $error("debug active under lockout");
  AST_LOCK_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    (rst_seen_q && SPECIAL_MODE_LOW) |=> $stable(lockout_disable_q))
    else $error("lockout changed in normal mode");
  AST_RESET_VEC: assert property (@(posedge MCLK) disable iff (RST)
    (!lockout_disable_q && SPECIAL_SINGLE_CHIP) |-> RESET_VECTOR_BLOCK)
    else $error("reset vector not blocked");
  AST_MAP_ONLY: assert property (@(posedge MCLK) disable iff (RST)
    (HIT && !instr_q[BIT_MAP]) |-> DEBUG_ACTIVE)
    else $error("registers mapped while inactive");
  AST_LOW_ZERO: assert property (@(posedge MCLK) disable iff (RST)
    instr_q[1:0] == 2'b00 && status_q[1:0] == 2'b00)
    else $error("low bits not zero");
  AST_NO_PERMIT: assert property (@(posedge MCLK) disable iff (RST)
    (!permit && !status_q[BIT_ACTIVE] && rst_seen_q)
    |=> !status_q[BIT_ACTIVE])
    else $error("entered debug without permit");
  sequence clear_write_s;
    wr_status && !instr_q[BIT_HWFW] && !WDATA[BIT_ACTIVE] && !ENTER_DEBUG;
  endsequence
  AST_ACTIVE_DELAY: assert property (@(posedge MCLK) disable iff (RST)
    clear_write_s ##1 !ENTER_DEBUG[*4] |=> !status_q[BIT_ACTIVE])
    else $error("active clear not after 4 cycles");
  AST_IDLE_CLEAR: assert property (@(posedge MCLK) disable iff (RST)
    (idle_q == IDLE_CLEAR_W && !SER_FALL) |=> instr_q == 8'h00)
    else $error("instruction not cleared when idle");
  AST_TRACE: assert property (@(posedge MCLK) disable iff (RST)
    (SINGLE_STEP && rst_seen_q) |=> status_q[BIT_TRACE])
    else $error("trace not set");
  AST_CLKSEL: assert property (@(posedge MCLK) disable iff (RST)
    BUS_SLOWER |-> USE_BUS_CLOCK)
    else $error("bus clock not forced");
  AST_SVALID: assert property (@(posedge MCLK) disable iff (RST)
    (SHIFT_DONE && rst_seen_q) |=> status_q[BIT_SVALID])
    else $error("shift valid not set");
  AST_BACKGROUND_REQUEST_BIT: assert property (@(posedge MCLK) disable iff (RST)
    BACKGROUND_REQUEST_BIT_REQ |-> instr_q == INSTR_BACKGROUND_REQUEST_BIT_CMD)
    else $error("background decode wrong");
endmodule : background_debug_control

// ===== logic/debug_ctrl_pkg.sv
// Contract
// - Debug holds bus; multi-cycle freezes processor
// - Lockout blocks active debug and ROM
// - Lockout when disable bit zero, reloaded
// - Lockout bit changes only in special modes
// - Erased shadow removes lockout after reset
// - Lockout blocks reset-vector run, special chip
// - Seven registers mapped while active or on hardware map-select
// - Status write qualifiers by hardware/firmware flag
// - Status reset value depends on mode
// - Permit bit gates entry to active debug
// - Active flag set on entry, 4-cycle write
// - Tag enable arms after 16 cycles
// - Shift-valid shows completed shift
// - Trace bit set by single-step command
// - Clock select, bus clock forced if slower
// - Instruction cleared after 512 idle clocks
// - Hardware instruction bit decode
// - Word/byte and map-select meaning
package debug_ctrl_pkg;
  localparam logic [15:0] ADDR_INSTR = 16'hFF00;
  localparam logic [15:0] ADDR_STATUS = 16'hFF01;
  localparam logic [15:0] ADDR_SHIFT_HI = 16'hFF02;
  localparam logic [15:0] ADDR_SHIFT_LO = 16'hFF03;
  localparam logic [15:0] ADDR_TADDR_HI = 16'hFF04;
  localparam logic [15:0] ADDR_TADDR_LO = 16'hFF05;
  localparam logic [15:0] ADDR_FLAGS = 16'hFF06;
  localparam logic [15:0] ADDR_ROM_LO = 16'hFF20;
  localparam int BIT_HWFW = 7;
  localparam int BIT_DATA = 6;
  localparam int BIT_READ = 5;
  localparam int BIT_BACKGROUND_REQUEST_BIT = 4;
  localparam int BIT_WORD = 3;
  localparam int BIT_MAP = 2;
  localparam int BIT_PERMIT = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_TAG = 5;
  localparam int BIT_SVALID = 4;
  localparam int BIT_TRACE = 3;
  localparam int BIT_CLKSEL = 2;
  localparam logic [7:0] INSTR_BACKGROUND_REQUEST_BIT_CMD = 8'h90;
  localparam logic [7:0] INSTR_MASK = 8'hFC;
  localparam logic [7:0] STATUS_RST_SPECIAL = 8'h40;
  localparam logic [7:0] STATUS_RST_OTHER = 8'h00;
  localparam logic [7:0] STATUS_ALWAYS_WR = 8'hB8;
  localparam int ACTIVE_DELAY = 4;
  localparam int TAG_DELAY = 16;
  localparam int IDLE_CLEAR = 512;
  localparam logic [2:0] ACTIVE_DLY_W = 3'h4;
  localparam logic [4:0] TAG_DLY_W = 5'h10;
  localparam logic [9:0] IDLE_CLEAR_W = 10'h200;
endpackage : debug_ctrl_pkg

// ===== logic/debug_access_if.sv
`timescale 1ns/1ps
interface debug_access_if;
  logic req;
  logic multi;
  logic busy;
  logic done;
  modport ctrl (output req, output multi, input busy, input done);
  modport seq (input req, input multi, output busy, output done);
endinterface : debug_access_if

// ===== logic/debug_access_seq.sv
`timescale 1ns/1ps
module debug_access_seq (
  input wire logic MCLK,
  input wire logic RST,
  debug_access_if.seq acc,
  input wire logic bus_ack,
  output logic freeze_q,
  output logic hold_q
);
  import debug_ctrl_pkg::*;
  logic done_q;
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      hold_q <= 1'b0;
    else if (acc.req)
      hold_q <= 1'b1;
    else if (bus_ack)
      hold_q <= 1'b0;
  end
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      freeze_q <= 1'b0;
    else if (acc.req && acc.multi)
      freeze_q <= 1'b1;
    else if (bus_ack)
      freeze_q <= 1'b0;
  end
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      done_q <= 1'b0;
    else
      done_q <= hold_q && bus_ack;
  end
  assign acc.busy = hold_q;
  assign acc.done = done_q;
  AST_FREEZE_HELD: assert property (@(posedge MCLK) disable iff (RST)
    freeze_q |-> hold_q)
    else $error("freeze without bus hold");
  AST_SINGLE_NOFRZ: assert property (@(posedge MCLK) disable iff (RST)
    (acc.req && !acc.multi && !freeze_q) |=> !freeze_q)
    else $error("single access froze processor");
endmodule : debug_access_seq

// ===== verification/debug_host_model.sv
`timescale 1ns/1ps
module debug_host_model (
  input wire logic MCLK,
  output logic SER_FALL,
  output logic SER_CMD_VALID,
  output logic [7:0] SER_CMD
);
  initial
  begin
    SER_FALL = 1'b0;
    SER_CMD_VALID = 1'b0;
    SER_CMD = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Eight falling edges per opcode, then the decoded byte for one cycle
  task automatic send(input logic [7:0] cmd);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge MCLK);
      SER_FALL <= 1'b1;
      @(posedge MCLK);
      SER_FALL <= 1'b0;
    end
    SER_CMD <= cmd;
    SER_CMD_VALID <= 1'b1;
    @(posedge MCLK);
    SER_CMD_VALID <= 1'b0;
    // Released byte flips so a stale value never looks valid
    SER_CMD <= ~cmd;
  endtask : send
  ////////////////////////////////////////////////////////////////////////////
  // Quiet time before the next command
  task automatic pace(input int kind);
    if (kind == 0)
      repeat (32) @(posedge MCLK);
    if (kind == 1)
      repeat (64) @(posedge MCLK);
    if (kind == 2)
      repeat (150) @(posedge MCLK);
  endtask : pace
endmodule : debug_host_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import debug_ctrl_pkg::*;
  logic MCLK, RST, sml, ssc, sper, shadow, cfg_d, wr, rd, slower, h;
  logic [15:0] addr, sload, aload;
  logic [7:0] wdata, flags, stb, rdata, v, st, c;
  logic [31:0] sa;
  logic sfall, svalid, lock_dis, active, rom, rvb, busclk, tagging, ser_en;
  logic bkg, hwc, hwd, hwr, hww, hwm, frz, hold, hit;
  logic [7:0] scmd;
  logic [7:0] cmds [9] = '{8'hE4, 8'hEC, 8'hE0, 8'hE8, 8'h90, 8'hC4,
    8'hCC, 8'hC0, 8'hC8};
  int seed, n_errors, checks_done, cycles;

  debug_host_model host (.MCLK(MCLK), .SER_FALL(sfall),
    .SER_CMD_VALID(svalid), .SER_CMD(scmd));
  background_debug_control dut (.MCLK(MCLK), .RST(RST),
    .SPECIAL_MODE_LOW(sml), .SPECIAL_SINGLE_CHIP(ssc),
    .SPECIAL_PERIPHERAL(sper), .SHADOW_LOCKOUT_DISABLE(shadow),
    .CFG_WR(stb[7]), .CFG_WR_DATA(cfg_d), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .HIT(hit), .SER_FALL(sfall),
    .SER_CMD_VALID(svalid), .SER_CMD(scmd), .SHIFT_DONE(stb[4]),
    .SHIFT_START(stb[3]), .SHIFT_LOAD(sload), .ADDR_LOAD(aload),
    .ADDR_LOAD_EN(stb[5]), .ENTER_DEBUG(stb[0]), .SINGLE_STEP(stb[1]),
    .TAG_RESUME(stb[2]), .BUS_SLOWER(slower), .FLAGS_IN(flags),
    .BUS_ACK(stb[6]), .LOCKOUT_DISABLE(lock_dis), .DEBUG_ACTIVE(active),
    .ROM_MAPPED(rom), .RESET_VECTOR_BLOCK(rvb), .USE_BUS_CLOCK(busclk),
    .TAGGING(tagging), .SERIAL_ENABLE(ser_en), .BACKGROUND_REQUEST_BIT_REQ(bkg),
    .HW_CMD(hwc), .HW_DATA(hwd), .HW_READ(hwr), .HW_WORD(hww),
    .HW_MAP_SELECT(hwm), .FREEZE(frz), .BUS_HOLD(hold));

  initial
  begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] status_exp(logic [7:0] o, w, logic hw);
    return (w & STATUS_ALWAYS_WR) | (o & 8'h40) | (hw ? w & 8'h04 : o & 8'h04);
  endfunction : status_exp
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick
  task automatic pulse(input int k);
    @(posedge MCLK);
    stb[k] <= 1'b1;
    @(posedge MCLK);
    stb[k] <= 1'b0;
    tick(1);
  endtask : pulse
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge MCLK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge MCLK);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a);
    @(posedge MCLK);
    addr <= a;
    rd <= 1'b1;
    #1 h = hit;
    @(posedge MCLK);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic reset(input logic sh, input logic sc);
    @(posedge MCLK);
    RST <= 1'b1;
    shadow <= sh;
    ssc <= sc;
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    tick(2);
  endtask : reset
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {RST, sml, sper, cfg_d, wr, rd, slower, stb} = 15'h4000;
    {addr, wdata, sload, aload, flags, cycles} = '0;
    {n_errors, checks_done, seed, st, ssc, shadow} = {64'h0, 32'd94, 10'h103};
    reset(1'b1, 1'b1);
    chk("lockout_disable", 16'(lock_dis), 16'h0001);
    rd_reg(ADDR_STATUS);
    chk("status_reset", 16'(v), 16'(STATUS_RST_SPECIAL));
    st = STATUS_RST_SPECIAL;
    for (int i = 0; i < 4; i++)
    begin
      flags = $random(seed);
      wr_reg(ADDR_FLAGS, flags);
      rd_reg(ADDR_FLAGS);
      chk("flags_save", 16'(v), 16'(flags));
      wdata = $random(seed);
      wdata = (wdata & 8'h9F) | 8'h40;
      wr_reg(ADDR_STATUS, wdata);
      st = status_exp(st, wdata, 1'b0);
      rd_reg(ADDR_STATUS);
      chk("status_write", 16'(v), 16'(st));
    end
    rd_reg(16'hFF07);
    chk("unmapped_hit", 16'(h), 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 9; i++)
    begin
      c = cmds[i];
      host.send(c);
      tick(1);
      chk("decode", 16'({hwc, hwd, hwr, bkg, hww, hwm}),
        16'({c[7:5], c[4] & st[BIT_PERMIT], c[3:2]}));
      if (c != INSTR_BACKGROUND_REQUEST_BIT_CMD)
        chk("bus_hold", 16'({hold, frz}), 16'({1'b1, c[3]}));
      pulse(6);
      tick(1);
      chk("bus_free", 16'({hold, frz}), 16'h0000);
      rd_reg(ADDR_INSTR);
      chk("instr_read", 16'(v), 16'(c & INSTR_MASK));
    end
    wr_reg(ADDR_STATUS, 8'hC4);
    st = status_exp(st, 8'hC4, 1'b1);
    host.pace(2);
    chk("bus_clock", 16'(busclk), 16'h0001);
    rd_reg(ADDR_STATUS);
    chk("clock_select", 16'(v), 16'(st));
    wr_reg(ADDR_STATUS, 8'hC0);
    tick(1);
    chk("base_clock", 16'(busclk), 16'h0000);
    @(posedge MCLK);
    slower <= 1'b1;
    tick(2);
    chk("forced_bus_clock", 16'(busclk), 16'h0001);
    $display("test commands done");
    host.send(INSTR_BACKGROUND_REQUEST_BIT_CMD);
    tick(490);
    chk("instr_kept", 16'(hwc), 16'h0001);
    tick(30);
    chk("instr_cleared", 16'(hwc), 16'h0000);
    $display("test idle clear done");
    wr_reg(ADDR_STATUS, 8'h80);
    chk("active_delay", 16'(active), 16'h0001);
    tick(3);
    chk("active_held", 16'(active), 16'h0001);
    tick(2);
    chk("active_cleared", 16'(active), 16'h0000);
    rd_reg(ADDR_STATUS);
    chk("map_closed", 16'(h), 16'h0000);
    flags = $random(seed);
    pulse(0);
    chk("entry", 16'({active, rom}), 16'h0003);
    rd_reg(ADDR_FLAGS);
    chk("flags_captured", 16'(v), 16'(flags));
    host.pace(0);
    pulse(1);
    rd_reg(ADDR_STATUS);
    chk("trace", 16'(v[BIT_TRACE]), 16'h0001);
    host.pace(1);
    pulse(2);
    tick(8);
    chk("tag_early", 16'(tagging), 16'h0000);
    tick(12);
    chk("tagging", 16'({tagging, ser_en}), 16'h0002);
    host.send(8'hC0);
    tick(1);
    chk("cmd_ignored", 16'(hwc), 16'h0000);
    pulse(0);
    tick(1);
    chk("tag_off", 16'(tagging), 16'h0000);
    $display("test active done");
    sload = $random(seed);
    aload = $random(seed);
    sa = {sload, aload};
    pulse(4);
    pulse(3);
    rd_reg(ADDR_STATUS);
    chk("shift_busy", 16'(v[BIT_SVALID]), 16'h0000);
    pulse(4);
    pulse(5);
    rd_reg(ADDR_STATUS);
    chk("shift_valid", 16'(v[BIT_SVALID]), 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(ADDR_SHIFT_HI + 16'(i));
      chk("shift_addr", 16'(v), 16'(sa[31 - 8 * i -: 8]));
    end
    $display("test shift done");
    // Shadow byte programmed for lockout
    reset(1'b0, 1'b1);
    chk("lockout", 16'({lock_dis, active, rom, rvb}), 16'h0001);
    pulse(0);
    chk("entry_locked", 16'(active), 16'h0000);
    @(posedge MCLK);
    {sml, cfg_d} <= 2'b11;
    pulse(7);
    chk("cfg_refused", 16'(lock_dis), 16'h0000);
    @(posedge MCLK);
    sml <= 1'b0;
    pulse(7);
    chk("cfg_special", 16'(lock_dis), 16'h0001);
    // Shadow byte erased, normal mode
    reset(1'b1, 1'b0);
    chk("unlocked", 16'({lock_dis, active}), 16'h0002);
    pulse(0);
    chk("no_permit", 16'(active), 16'h0000);
    host.send(8'hC8);
    tick(1);
    chk("hw_still_runs", 16'(hwc), 16'h0001);
    @(posedge MCLK);
    sper <= 1'b1;
    reset(1'b1, 1'b0);
    chk("periph_reset", 16'(active), 16'h0001);
    wr_reg(ADDR_INSTR, 8'hE7);
    rd_reg(ADDR_INSTR);
    chk("instr_write", 16'(v), 16'h00E4);
    $display("test lockout done");
    test_done();
  end
endmodule : tb_top
